// file: rtl/xfer_pkg.sv
// shared constants of the descriptor transfer core
// assumes a 32-bit descriptor RAM of 1 kbyte and 24-bit data addresses
package xfer_pkg;

    // ----------------------------------------------------------
    // widths
    // ----------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int DRAM_AW = 8;
    localparam int SRC_N = 8;
    localparam int DESC_RAM_BYTES = 1024;

    // ----------------------------------------------------------
    // control register offsets and reset values
    // ----------------------------------------------------------
    localparam logic [7:0] ENABLE_OFS = 8'h00;
    localparam logic [7:0] VECTOR_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [7:0] VECTOR_RST = 8'h00;
    localparam int SW_START_BIT = 7;

    // ----------------------------------------------------------
    // descriptor_mode_a / descriptor_mode_b fields
    // ----------------------------------------------------------
    localparam int SRC_MODE_HI = 7;
    localparam int SRC_MODE_LO = 6;
    localparam int DST_MODE_HI = 5;
    localparam int DST_MODE_LO = 4;
    localparam int KIND_HI = 3;
    localparam int KIND_LO = 2;
    localparam int AREA_BIT = 1;
    localparam int SIZE_BIT = 0;
    localparam int CHAIN_BIT = 7;
    localparam int IRQ_EVERY_BIT = 6;
    localparam logic [1:0] KIND_NORMAL = 2'h0;
    localparam logic [1:0] KIND_REPEAT = 2'h1;
    localparam logic [1:0] KIND_BLOCK = 2'h2;

    // ----------------------------------------------------------
    // descriptor placement in RAM, in 32-bit words
    // ----------------------------------------------------------
    localparam logic [7:0] DESC_STRIDE = 8'h04;

    typedef enum logic [3:0] {
        ST_IDLE, ST_GRANT, ST_RD1, ST_RD2, ST_RD3, ST_RD4,
        ST_DRD, ST_DWR, ST_WB1, ST_WB2, ST_FIN
    } xfer_state_t;

endpackage

// file: rtl/addr_stepper.sv
// next-address logic for one pointer of the transfer core
// assumes the mode field and size bit of the current descriptor
`timescale 1ns/100ps
module addr_stepper (
    input wire logic [1:0] mode,
    input wire logic word,
    input wire logic [xfer_pkg::ADDR_W-1:0] cur,
    output logic [xfer_pkg::ADDR_W-1:0] nxt
);
    import xfer_pkg::*;

    logic [ADDR_W-1:0] step;

    // words step by two, bytes by one, over a flat 24-bit space
    always_comb begin
        step = word ? 24'h000002 : 24'h000001;
        if (!mode[1]) begin
            nxt = cur;
        end else if (!mode[0]) begin
            nxt = cur + step;
        end else begin
            nxt = cur - step;
        end
    end

endmodule

// file: rtl/transfer_controller.sv
// descriptor driven data transfer core with its control registers
// assumes one-cycle descriptor RAM reads, a ready-handshaked data bus and an arbiter grant
`timescale 1ns/100ps
module transfer_controller (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [xfer_pkg::SRC_N-1:0] act_req,
    output logic src_clr,
    output logic [2:0] src_clr_idx,
    output logic cpu_irq,
    output logic bus_req,
    input wire logic bus_gnt,
    output logic dram_re,
    output logic dram_we,
    output logic [xfer_pkg::DRAM_AW-1:0] dram_addr,
    output logic [31:0] dram_wdata,
    input wire logic [31:0] dram_rdata,
    output logic mem_rd,
    output logic mem_wr,
    output logic mem_word,
    output logic [xfer_pkg::ADDR_W-1:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ready
);
    import xfer_pkg::*;

    // ----------------------------------------------------------
    // state of the core
    // ----------------------------------------------------------
    typedef struct packed {
        xfer_state_t st;
        logic [7:0] en;
        logic sw_go;
        logic [6:0] vec;
        logic [5:0] chan;
        logic from_sw;
        logic [7:0] ptr;
        logic [7:0] mode_a;
        logic [7:0] mode_b;
        logic [ADDR_W-1:0] src;
        logic [ADDR_W-1:0] dst;
        logic [15:0] cnt_a;
        logic [15:0] cnt_b;
        logic ended;
        logic [7:0] rdata;
        logic irq;
        logic clr;
        logic [2:0] clr_idx;
        logic breq;
        logic re;
        logic we;
        logic [7:0] daddr;
        logic [31:0] wdata;
        logic mrd;
        logic mwr;
        logic mword;
        logic [ADDR_W-1:0] maddr;
        logic [15:0] mwdata;
    } core_t;

    core_t s_q;
    core_t s_d;

    logic [ADDR_W-1:0] src_nx;
    logic [ADDR_W-1:0] dst_nx;
    logic [7:0] hit;
    logic [5:0] pick;
    logic [7:0] low;
    logic more;
    logic fin_hit;
    logic [1:0] kind;

    // ----------------------------------------------------------
    // helpers
    // ----------------------------------------------------------

    // lowest numbered pending source wins
    function automatic logic [2:0] first_set(input logic [7:0] v);
        first_set = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 3'(i);
            end
        end
    endfunction

    // word address of one beat of the current descriptor
    function automatic logic [7:0] beat(input logic [7:0] p, input logic [1:0] k);
        beat = p + {6'h00, k};
    endfunction

    // undo n steps of a moving pointer, used when an area wraps
    function automatic logic [ADDR_W-1:0] rewind(input logic [ADDR_W-1:0] a,
        input logic [1:0] m, input logic w, input logic [7:0] n);
        logic [ADDR_W-1:0] span;
        span = w ? {15'h0000, n, 1'b0} : {16'h0000, n};
        if (!m[1]) begin
            rewind = a;
        end else if (!m[0]) begin
            rewind = a - span;
        end else begin
            rewind = a + span;
        end
    endfunction

    // ----------------------------------------------------------
    // pointer stepping
    // ----------------------------------------------------------
    // source stepping
    addr_stepper u_src_step (
        .mode(s_q.mode_a[SRC_MODE_HI:SRC_MODE_LO]),
        .word(s_q.mode_a[SIZE_BIT]),
        .cur(s_q.src),
        .nxt(src_nx)
    );

    addr_stepper u_dst_step (
        .mode(s_q.mode_a[DST_MODE_HI:DST_MODE_LO]),
        .word(s_q.mode_a[SIZE_BIT]),
        .cur(s_q.dst),
        .nxt(dst_nx)
    );

    // ----------------------------------------------------------
    // next state
    // ----------------------------------------------------------
    always_comb begin
        s_d = s_q;
        hit = act_req & s_q.en;
        pick = s_q.vec[5:0];
        low = 8'h00;
        more = 1'b0;
        fin_hit = 1'b0;
        kind = s_q.mode_a[KIND_HI:KIND_LO];
        s_d.irq = 1'b0;
        s_d.clr = 1'b0;
        s_d.rdata = 8'h00;
        unique case (s_q.st)
            // interrupt sources before a software request
            ST_IDLE: begin
                if (|hit || s_q.sw_go) begin
                    if (|hit) begin
                        pick = {3'h0, first_set(hit)};
                    end
                    s_d.from_sw = ~|hit;
                    s_d.chan = pick;
                    s_d.ptr = {pick, 2'h0};
                    s_d.breq = 1'b1;
                    s_d.st = ST_GRANT;
                end
            end
            ST_GRANT: begin
                if (bus_gnt) begin
                    s_d.re = 1'b1;
                    s_d.daddr = s_q.ptr;
                    s_d.st = ST_RD1;
                end
            end
            // three 32-bit beats, data one cycle behind the address
            ST_RD1: begin
                s_d.daddr = beat(s_q.ptr, 2'h1);
                s_d.st = ST_RD2;
            end
            // mode a shares the word with the source pointer
            ST_RD2: begin
                s_d.mode_a = dram_rdata[31:24];
                s_d.src = dram_rdata[23:0];
                s_d.daddr = beat(s_q.ptr, 2'h2);
                s_d.st = ST_RD3;
            end
            // reserved mode b bits are kept but never looked at
            ST_RD3: begin
                s_d.mode_b = dram_rdata[31:24];
                s_d.dst = dram_rdata[23:0];
                s_d.re = 1'b0;
                s_d.st = ST_RD4;
            end
            // size bit sets the width of every move
            ST_RD4: begin
                s_d.cnt_a = dram_rdata[31:16];
                s_d.cnt_b = dram_rdata[15:0];
                s_d.mrd = 1'b1;
                s_d.maddr = s_q.src;
                s_d.mword = s_q.mode_a[SIZE_BIT];
                s_d.st = ST_DRD;
            end
            // read side of one move; the bus may hold us off
            ST_DRD: begin
                if (mem_ready) begin
                    s_d.mrd = 1'b0;
                    s_d.mwr = 1'b1;
                    s_d.maddr = s_q.dst;
                    s_d.mwdata = mem_rdata;
                    s_d.st = ST_DWR;
                end
            end
            // write side, then pointer and count update
            ST_DWR: begin
                if (mem_ready) begin
                    s_d.mwr = 1'b0;
                    s_d.src = src_nx;
                    s_d.dst = dst_nx;
                    s_d.ended = 1'b0;
                    if (kind == KIND_REPEAT || kind == KIND_BLOCK) begin
                        // low byte counts, high byte reloads it
                        low = s_q.cnt_a[7:0] - 8'h01;
                        if (low == 8'h00) begin
                            s_d.cnt_a[7:0] = s_q.cnt_a[15:8];
                            // only the area side returns to its start
                            if (s_q.mode_a[AREA_BIT]) begin
                                s_d.src = rewind(src_nx, s_q.mode_a[SRC_MODE_HI:SRC_MODE_LO],
                                    s_q.mode_a[SIZE_BIT], s_q.cnt_a[15:8]);
                            end else begin
                                s_d.dst = rewind(dst_nx, s_q.mode_a[DST_MODE_HI:DST_MODE_LO],
                                    s_q.mode_a[SIZE_BIT], s_q.cnt_a[15:8]);
                            end
                            if (kind == KIND_BLOCK) begin
                                s_d.cnt_b = s_q.cnt_b - 16'h0001;
                                s_d.ended = (s_q.cnt_b == 16'h0001);
                            end
                        end else begin
                            s_d.cnt_a[7:0] = low;
                            more = (kind == KIND_BLOCK);
                        end
                    end else begin
                        // normal mode, forbidden code 11 runs as normal
                        s_d.cnt_a = s_q.cnt_a - 16'h0001;
                        s_d.ended = (s_q.cnt_a == 16'h0001);
                    end
                    if (more) begin
                        // a block keeps the bus until all its units moved
                        s_d.mrd = 1'b1;
                        s_d.maddr = src_nx;
                        s_d.st = ST_DRD;
                    end else begin
                        // write back starts with the first word
                        s_d.we = 1'b1;
                        s_d.daddr = s_q.ptr;
                        s_d.wdata = {s_q.mode_a, s_d.src};
                        s_d.st = ST_WB1;
                    end
                end
            end
            ST_WB1: begin
                s_d.daddr = beat(s_q.ptr, 2'h1);
                s_d.wdata = {s_q.mode_b, s_q.dst};
                s_d.st = ST_WB2;
            end
            ST_WB2: begin
                s_d.daddr = beat(s_q.ptr, 2'h2);
                s_d.wdata = {s_q.cnt_a, s_q.cnt_b};
                s_d.st = ST_FIN;
            end
            ST_FIN: begin
                s_d.we = 1'b0;
                if (s_q.mode_b[CHAIN_BIT]) begin
                    // next descriptor under the same grant, no end actions
                    s_d.ptr = s_q.ptr + DESC_STRIDE;
                    s_d.re = 1'b1;
                    s_d.daddr = s_q.ptr + DESC_STRIDE;
                    s_d.st = ST_RD1;
                end else begin
                    // interrupt per transfer or at count end
                    fin_hit = s_q.mode_b[IRQ_EVERY_BIT] | s_q.ended;
                    s_d.irq = fin_hit;
                    s_d.breq = 1'b0;
                    s_d.st = ST_IDLE;
                    if (s_q.from_sw) begin
                        if (!fin_hit) begin
                            s_d.sw_go = 1'b0;
                        end
                    end else if (fin_hit) begin
                        s_d.en[s_q.chan[2:0]] = 1'b0;
                    end else begin
                        s_d.clr = 1'b1;
                        s_d.clr_idx = s_q.chan[2:0];
                    end
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase

        // software writes land after hardware clears, so a set is never lost
        if (reg_wr && reg_addr == ENABLE_OFS) begin
            s_d.en = reg_wdata;
        end
        if (reg_wr && reg_addr == VECTOR_OFS) begin
            if (!s_q.sw_go) begin
                s_d.vec = reg_wdata[6:0];
            end
            if (reg_wdata[SW_START_BIT]) begin
                s_d.sw_go = 1'b1;
            end
        end

        // working registers have no address here
        if (reg_rd) begin
            case (reg_addr)
                ENABLE_OFS: s_d.rdata = s_q.en;
                VECTOR_OFS: s_d.rdata = {s_q.sw_go, s_q.vec};
                STATUS_OFS: s_d.rdata = {s_q.st != ST_IDLE, s_q.from_sw, s_q.chan};
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------
    // state register
    // ----------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.en <= ENABLE_RST;
            s_q.vec <= VECTOR_RST[6:0];
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign reg_rdata = s_q.rdata;
    assign src_clr = s_q.clr;
    assign src_clr_idx = s_q.clr_idx;
    assign cpu_irq = s_q.irq;
    assign bus_req = s_q.breq;
    assign dram_re = s_q.re;
    assign dram_we = s_q.we;
    assign dram_addr = s_q.daddr;
    assign dram_wdata = s_q.wdata;
    assign mem_rd = s_q.mrd;
    assign mem_wr = s_q.mwr;
    assign mem_word = s_q.mword;
    assign mem_addr = s_q.maddr;
    assign mem_wdata = s_q.mwdata;

    // ----------------------------------------------------------
    // checks
    // ----------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence load_beats;
        dram_re [*3] ##1 !dram_re;
    endsequence

    chk_bus_held: assert property ((dram_re | dram_we | mem_rd | mem_wr) |-> bus_req)
        else $error("access without bus request");

    chk_desc_load: assert property ((s_q.st == ST_GRANT && bus_gnt) |=> load_beats)
        else $error("descriptor load is not three beats");

    chk_beat_addr: assert property (dram_re && $past(dram_re) |-> dram_addr == 8'($past(dram_addr) + 8'h01))
        else $error("descriptor beats not consecutive");

    chk_desc_store: assert property ($rose(dram_we) |-> dram_we [*3] ##1 !dram_we)
        else $error("write back is not three beats");

    chk_src_fixed: assert property ((s_q.st == ST_DWR && mem_ready && !s_q.mode_a[SRC_MODE_HI])
        |=> s_q.src == $past(s_q.src))
        else $error("fixed source pointer moved");

    chk_src_step: assert property ((s_q.st == ST_DWR && mem_ready && kind == KIND_NORMAL
        && s_q.mode_a[SRC_MODE_HI:SRC_MODE_LO] == 2'h2)
        |=> s_q.src == $past(s_q.src) + ($past(s_q.mode_a[SIZE_BIT]) ? 24'h000002 : 24'h000001))
        else $error("source step wrong");

    chk_dst_dec: assert property ((s_q.st == ST_DWR && mem_ready && kind == KIND_NORMAL
        && s_q.mode_a[DST_MODE_HI:DST_MODE_LO] == 2'h3)
        |=> s_q.dst == $past(s_q.dst) - ($past(s_q.mode_a[SIZE_BIT]) ? 24'h000002 : 24'h000001))
        else $error("destination step wrong");

    chk_unit_size: assert property ((mem_rd | mem_wr) |-> mem_word == s_q.mode_a[SIZE_BIT])
        else $error("move width differs from size bit");

    chk_irq_every: assert property ((s_q.st == ST_FIN && !s_q.mode_b[CHAIN_BIT]
        && s_q.mode_b[IRQ_EVERY_BIT]) |=> cpu_irq ##1 !cpu_irq)
        else $error("missing per transfer interrupt");

    chk_chain_quiet: assert property ((s_q.st == ST_FIN && s_q.mode_b[CHAIN_BIT])
        |=> !cpu_irq && !src_clr && dram_re && bus_req)
        else $error("chained descriptor raised an end action");

endmodule

// file: tb/xfer_partner.sv
// partner model: descriptor RAM, data memory and bus arbiter
// assumes the core's registered strobes; wait_n sets the data wait states
`timescale 1ns/100ps
module xfer_partner (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [1:0] wait_n,
    input wire logic bus_req,
    output logic bus_gnt,
    input wire logic dram_re,
    input wire logic dram_we,
    input wire logic [xfer_pkg::DRAM_AW-1:0] dram_addr,
    input wire logic [31:0] dram_wdata,
    output logic [31:0] dram_rdata,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic mem_word,
    input wire logic [xfer_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata,
    output logic mem_ready
);
    import xfer_pkg::*;
    // 1 kbyte held as 256 words
    logic [31:0] ram [0:255];
    logic [40:0] wlog [$];
    logic [1:0] cnt_q;
    logic [15:0] pat;
    // read data follow the address; inverted outside an answer so stale data never match
    assign pat = {mem_addr[7:0] ^ 8'h5A, mem_addr[7:0]};
    assign mem_rdata = mem_ready ? pat : ~pat;
    // ----------------------------------------------------------
    // RAM beats, grant and data handshake
    // ----------------------------------------------------------
    // RAM enabled, one beat per state
    // plain always: the bench preloads the RAM and drains the log from outside
    always @(posedge sys_clk) begin
        bus_gnt <= bus_req & ~rst;
        dram_rdata <= dram_re ? ram[dram_addr] : ~dram_rdata;
        if (dram_we) begin
            ram[dram_addr] <= dram_wdata;
        end
        mem_ready <= 1'b0;
        if (rst) begin
            cnt_q <= 2'h0;
            dram_rdata <= 32'h0;
        end else if ((mem_rd | mem_wr) & ~mem_ready) begin
            if (cnt_q == wait_n) begin
                mem_ready <= 1'b1;
                cnt_q <= 2'h0;
                if (mem_wr) begin
                    wlog.push_back({mem_word, mem_addr, mem_word ? mem_wdata[15:8] : 8'h00, mem_wdata[7:0]});
                end
            end else begin
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end
endmodule

// file: tb/transfer_controller_test.sv
// self-checking bench for the descriptor transfer core
// assumes xfer_partner as descriptor RAM, data memory and arbiter
`timescale 1ns/100ps
module transfer_controller_test;
    import xfer_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [SRC_N-1:0] act_req = '0;
    logic src_clr, cpu_irq, bus_req, bus_gnt, dram_re, dram_we, mem_rd, mem_wr, mem_word, mem_ready;
    logic [2:0] src_clr_idx;
    logic [2:0] clr_idx;
    logic [DRAM_AW-1:0] dram_addr;
    logic [31:0] dram_wdata, dram_rdata;
    logic [ADDR_W-1:0] mem_addr;
    logic [15:0] mem_wdata, mem_rdata;
    logic [1:0] wait_n = 2'h0;
    int mismatches = 0;
    int cmp_count = 0;
    int irq_n = 0;
    int clr_n = 0;

    always #50 sys_clk = ~sys_clk;

    transfer_controller dut_u (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .act_req,
        .src_clr, .src_clr_idx, .cpu_irq, .bus_req, .bus_gnt, .dram_re, .dram_we, .dram_addr, .dram_wdata,
        .dram_rdata, .mem_rd, .mem_wr, .mem_word, .mem_addr, .mem_wdata, .mem_rdata, .mem_ready);
    xfer_partner pu (.sys_clk, .rst, .wait_n, .bus_req, .bus_gnt, .dram_re, .dram_we, .dram_addr, .dram_wdata,
        .dram_rdata, .mem_rd, .mem_wr, .mem_word, .mem_addr, .mem_wdata, .mem_rdata, .mem_ready);

    // count completion pulses; read at the edge, before the core's updates land
    always @(posedge sys_clk) begin
        if (cpu_irq === 1'b1) irq_n++;
        if (src_clr === 1'b1) begin
            clr_n++;
            clr_idx = src_clr_idx;
        end
    end

    // ----------------------------------------------------------
    // access and compare tasks
    // ----------------------------------------------------------
    task automatic chk(input logic [40:0] got, input logic [40:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so look just past that edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
        // return on an edge so the next request is driven there
        @(posedge sys_clk);
    endtask

    // one activation by source ch or by software, waited out under a bound
    task automatic go(input int ch, input bit sw);
        int n;
        n = 0;
        if (sw) wr(VECTOR_OFS, 8'h80 | 8'(ch));
        else act_req[ch] <= 1'b1;
        // bus_req is read at the edge, before that edge's update lands
        while (bus_req !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        act_req <= '0;
        if (bus_req !== 1'b1) n = 300;
        while (bus_req !== 1'b0 && n < 300) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 300) begin
            mismatches++;
            $display("unexpected at %0t: activation hangs", $time);
            test_done();
        end
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic desc(input int w, input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
        pu.ram[w] = a;
        pu.ram[w + 1] = b;
        pu.ram[w + 2] = c;
    endtask

    task automatic wb(input int w, input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
        chk(pu.ram[w], a);
        chk(pu.ram[w + 1], b);
        chk(pu.ram[w + 2], c);
    endtask

    // one data move: destination, size and the data read from the source
    task automatic mv(input logic w, input logic [23:0] s, input logic [23:0] d);
        logic [40:0] e;
        e = {w, d, (w ? (s[7:0] ^ 8'h5A) : 8'h00), s[7:0]};
        chk(pu.wlog.size() > 0 ? pu.wlog.pop_front() : 41'hx, e);
    endtask

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(ENABLE_OFS, ENABLE_RST);
        rd(VECTOR_OFS, VECTOR_RST);
        rd(STATUS_OFS, 8'h00);
        for (int a = 12; a < 32; a += 4) begin
            wr(8'(a), 8'hFF);
            rd(8'(a), 8'h00);
        end
        wr(ENABLE_OFS, 8'hFE);
        rd(ENABLE_OFS, 8'hFE);
        // a request from a disabled source must not start anything
        act_req <= 8'h01;
        repeat (3) @(posedge sys_clk);
        act_req <= '0;
        chk(bus_req, 0);
        @(posedge sys_clk);
        $display("registers done");
        // normal byte moves, both pointers counting up, two activations
        desc(4, {8'hA0, 24'h001234}, {8'h00, 24'h00205A}, {16'h0002, 16'h0000});
        go(1, 0);
        mv(0, 24'h001234, 24'h00205A);
        wb(4, {8'hA0, 24'h001235}, {8'h00, 24'h00205B}, {16'h0001, 16'h0000});
        chk(clr_n, 1);
        chk(clr_idx, 1);
        go(1, 0);
        mv(0, 24'h001235, 24'h00205B);
        wb(4, {8'hA0, 24'h001236}, {8'h00, 24'h00205C}, {16'h0000, 16'h0000});
        chk(irq_n, 1);
        rd(ENABLE_OFS, 8'hFC);
        $display("normal done");
        // software start, word moves counting down, count not ended
        desc(8, {8'hF1, 24'h001100}, {8'h00, 24'h003300}, {16'h0005, 16'h0000});
        go(2, 1);
        mv(1, 24'h001100, 24'h003300);
        wb(8, {8'hF1, 24'h0010FE}, {8'h00, 24'h0032FE}, {16'h0004, 16'h0000});
        rd(VECTOR_OFS, 8'h02);
        rd(STATUS_OFS, 8'h42);
        chk(irq_n, 1);
        $display("software done");
        // interrupt after every transfer, fixed source, slow memory
        wait_n <= 2'h2;
        desc(12, {8'h61, 24'h001000}, {8'h40, 24'h004000}, {16'h0005, 16'h0000});
        go(3, 0);
        mv(1, 24'h001000, 24'h004000);
        wb(12, {8'h61, 24'h001000}, {8'h40, 24'h004002}, {16'h0004, 16'h0000});
        chk(irq_n, 2);
        rd(ENABLE_OFS, 8'hF4);
        wait_n <= 2'h0;
        $display("every transfer done");
        // chained pair: the first ends its count but must not finish the activation
        desc(16, {8'hA0, 24'h001000}, {8'h80, 24'h005000}, {16'h0001, 16'h0000});
        desc(20, {8'h80, 24'h001100}, {8'h00, 24'h005100}, {16'h0003, 16'h0000});
        go(4, 0);
        mv(0, 24'h001000, 24'h005000);
        mv(0, 24'h001100, 24'h005100);
        wb(16, {8'hA0, 24'h001001}, {8'h80, 24'h005001}, {16'h0000, 16'h0000});
        wb(20, {8'h80, 24'h001101}, {8'h00, 24'h005100}, {16'h0002, 16'h0000});
        chk(irq_n, 2);
        chk(clr_n, 2);
        chk(clr_idx, 4);
        rd(ENABLE_OFS, 8'hF4);
        rd(STATUS_OFS, 8'h04);
        $display("chain done");
        // repeat mode, destination area wraps after two transfers
        desc(24, {8'hA4, 24'h001000}, {8'h00, 24'h006000}, {16'h0202, 16'h0000});
        go(6, 0);
        go(6, 0);
        mv(0, 24'h001000, 24'h006000);
        mv(0, 24'h001001, 24'h006001);
        wb(24, {8'hA4, 24'h001002}, {8'h00, 24'h006000}, {16'h0202, 16'h0000});
        chk(clr_n, 4);
        $display("repeat done");
        // block mode, source area, one block of two words ends the block count
        desc(28, {8'hAB, 24'h001000}, {8'h00, 24'h007000}, {16'h0202, 16'h0001});
        go(7, 0);
        mv(1, 24'h001000, 24'h007000);
        mv(1, 24'h001002, 24'h007002);
        wb(28, {8'hAB, 24'h001000}, {8'h00, 24'h007004}, {16'h0202, 16'h0000});
        chk(irq_n, 3);
        rd(ENABLE_OFS, 8'h74);
        chk(pu.wlog.size(), 0);
        $display("block done");
        test_done();
    end
endmodule
